//--- bench/uesc_capture_tb.sv
// Self-checking bench for the urgent error status capture block
`timescale 1ns/1ps
`include "uesc_params.svh"

module uesc_capture_tb
  import uesc_pkg::*;
;
  logic         clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o, handler_active_i;
  logic         fatal_error_o, single_trap_o, multiple_trap_o, instr_abandon_o;
  logic [7:0]   adr_i;
  logic [3:0]   sel_i;
  logic [31:0]  dat_i, dat_o, rs;
  logic [63:0]  urgent_error_status_o, es;
  logic [63:16] err_upper_i, pu;
  uesc_evt_t    evt_i;
  uesc_trap_t   trap_i;
  int           miscompares, n_compared;
  logic [33:0]  bq[$];
  logic [3:0]   pq[$];
  logic [63:0]  sq[$];
  logic [15:0]  fl[14] = '{16'h8000, 16'h8000, 16'h0000, 16'h8000, 16'h8000, 16'h8000, 16'h4000,
                         16'h0400, 16'h0400, 16'h0400, 16'h0200, 16'h0200, 16'h0200, 16'h0100};

  uesc_capture uesc_capture_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .evt_i(evt_i), .err_upper_i(err_upper_i), .trap_i(trap_i), .handler_active_i(handler_active_i),
    .fatal_error_o(fatal_error_o), .single_trap_o(single_trap_o), .multiple_trap_o(multiple_trap_o),
    .instr_abandon_o(instr_abandon_o), .urgent_error_status_o(urgent_error_status_o));

  uesc_trap_model uesc_trap_model_i (.clk_i(clk_i), .evt_o(evt_i), .upper_o(err_upper_i),
    .trap_o(trap_i), .handler_o(handler_active_i));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Xorshift source
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  // Compare and count
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic end_sim();
    if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Classic Wishbone cycle; note holds {check data, err, data}
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] ex);
    int n;
    bq.push_back(ex);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      end_sim();
    end else begin
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
    end
  endtask

  // Read both status words against the expected image
  task automatic rd_stat();
    wb(1'b0, `UESC_OFS_STAT_LO, 32'h0, {2'b10, es[31:0]});
    wb(1'b0, `UESC_OFS_STAT_HI, 32'h0, {2'b10, es[63:32]});
  endtask

  // Detector report for each table entry
  function automatic uesc_evt_t ev(input int k);
    uesc_evt_t e;
    e = '0;
    e.acc_valid = (k >= 1 && k <= 3);
    e.acc_cacheable = (k == 1 || k == 2);
    e.acc_pa = (k == 1) ? `UESC_PA_LIMIT : (k == 2) ? 43'h3fe_ffff_ffc0 : 43'h001_0000_0000;
    e.small_corrupt = (k == 0);
    e.dbuf_tag_err = (k == 4);
    e.ext_damage = (k == 5);
    e.wdt_first = (k == 6);
    e.dtlb_load_ue = (k == 7);
    e.dtlb_write_fail = (k == 8);
    e.dtlb_demap_fail = (k == 9);
    e.itlb_load_ue = (k == 10);
    e.itlb_write_fail = (k == 11);
    e.itlb_demap_fail = (k == 12);
    e.core_ue = (k == 13);
    return e;
  endfunction

  // Random trap fields with given causes
  task automatic mk_trap(output uesc_trap_t t, output logic [63:16] up, input logic [2:0] c);
    logic [31:0] r;
    r = rnd();
    up = {r[15:0], rnd()};
    t = '0;
    t.req = 1'b1;
    t.end_method = (r[17:16] == 2'h2) ? UESC_END_NO_RETRY : uesc_end_t'(r[17:16]);
    t.supervisor_mode_copy = r[18];
    t.pstate_ue = r[19];
    {t.cause_dae, t.cause_iae, t.cause_iuge} = c;
  endtask

  // Event then single trap; random causes must still clear bits 2:0
  task automatic single_trap(input uesc_evt_t e, input logic [15:0] f);
    uesc_trap_t t;
    logic [63:16] up;
    int g;
    mk_trap(t, up, 3'(rnd()));
    es = {up | pu, f | {10'h0, f[14] ? 2'h0 : t.end_method, t.supervisor_mode_copy | t.pstate_ue, 3'h0}};
    pu = '0;
    sq.push_back(es);
    pq.push_back({1'b0, 1'b1, 1'b0, f[14]});
    // Same cycle for watchdog and high address, one quiet cycle for small corruption
    g = (e.wdt_first || (e.acc_cacheable && e.acc_pa >= `UESC_PA_LIMIT)) ? 0 : e.small_corrupt ? 2 : 1 + rnd() % 3;
    fork
      if (e !== '0) uesc_trap_model_i.pulse_evt(e);
      uesc_trap_model_i.take_trap(t, 1'b0, up, g);
    join
    rd_stat();
  endtask

  // Nested trap: only cause bits move, new indications wait
  task automatic multi_trap(input logic [2:0] c);
    uesc_trap_t t;
    logic [63:16] up;
    mk_trap(t, up, c);
    es[2:0] = es[2:0] | c;
    pu = pu | up;
    sq.push_back(es);
    pq.push_back(4'b0010);
    uesc_trap_model_i.take_trap(t, 1'b1, up, 0);
    rd_stat();
  endtask

  // ----------------------------------------------------------------
  // Monitors
  // ----------------------------------------------------------------
  // Bus answers against the oldest note
  always @(negedge clk_i) begin
    logic [33:0] b;
    if (ack_o === 1'b1 || err_o === 1'b1) begin
      b = (bq.size() > 0) ? bq.pop_front() : 34'h3_ffff_ffff;
      check("bus_err", err_o, b[32]);
      if (b[33]) check("bus_data", dat_o, b[31:0]);
    end
  end

  // Result pulses against the oldest note
  always @(negedge clk_i) begin
    logic [3:0] p;
    p = {fatal_error_o, single_trap_o, multiple_trap_o, instr_abandon_o};
    if (p !== 4'h0) check("pulses", p, (pq.size() > 0) ? pq.pop_front() : 4'h0);
    // Status image changes at the same edge as the trap pulse
    if (single_trap_o === 1'b1 || multiple_trap_o === 1'b1) begin
      check("status", urgent_error_status_o, (sq.size() > 0) ? sq.pop_front() : 64'h0);
    end
  end

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  initial begin
    #(25 * 20000);
    miscompares++;
    end_sim();
  end

  initial begin
    {cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
    sel_i = 4'hf;
    rst_i = 1'b1;
    rs = 32'h88d4;
    {es, pu, miscompares, n_compared} = '0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_stat();
    wb(1'b0, `UESC_OFS_CFG, 32'h0, {2'b10, 32'h0});
    wb(1'b1, `UESC_OFS_STAT_LO, rnd(), 34'h0);
    wb(1'b1, `UESC_OFS_STAT_HI, rnd(), 34'h0);
    wb(1'b0, 8'h0c, 32'h0, {2'b11, 32'h0});
    rd_stat();
    wb(1'b1, `UESC_OFS_CFG, 32'h0001_0000, 34'h0);
    for (int k = 0; k < 14; k++) single_trap(ev(k), fl[k]);
    multi_trap(3'b000);
    multi_trap(3'b100);
    multi_trap(3'b010);
    multi_trap(3'b001);
    wb(1'b1, `UESC_OFS_CFG, 32'h0001_0001, 34'h0);
    pq.push_back(4'b1000);
    single_trap(ev(5), 16'h0000);
    check("queues", bq.size() + pq.size() + sq.size(), 64'h0);
    end_sim();
  end
endmodule // uesc_capture_tb

//--- bench/uesc_trap_model.sv
// Behavioural model of the error detectors and the trap logic
`timescale 1ns/1ps

module uesc_trap_model
  import uesc_pkg::*;
(
  input  wire logic         clk_i,
  output uesc_evt_t         evt_o,
  output logic      [63:16] upper_o,
  output uesc_trap_t        trap_o,
  output logic              handler_o
);
  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  // Quiet at time zero, handler not running
  initial begin
    evt_o = '0;
    upper_o = '0;
    trap_o = '0;
    handler_o = 1'b0;
  end

  // One-cycle detector pulse, released to zero after
  task automatic pulse_evt(input uesc_evt_t e);
    @(posedge clk_i);
    evt_o <= e;
    @(posedge clk_i);
    evt_o <= '0;
  endtask

  // Trap request after a gap; handler level is held afterwards
  task automatic take_trap(input uesc_trap_t t, input logic h, input logic [63:16] up, input int gap);
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    trap_o <= t;
    upper_o <= up;
    handler_o <= h;
    @(posedge clk_i);
    trap_o <= '0;
    upper_o <= '0;
  endtask
endmodule // uesc_trap_model

//--- src/uesc_capture.sv
// Urgent error status capture with a Wishbone register port
// What this block does
// - Small data corruption sets the corruption flag
// - Cacheable access at high address sets corruption
// - Access in masked address region sets corruption
// - Config picks fatal error or corruption flag
// - Data buffer tag errors set corruption flag
// - Bit 14 first watchdog; trapped instruction abandoned
// - Data buffer load uncorrectable error sets bit 10
// - Data buffer write or demap failure sets 10
// - Instruction buffer load uncorrectable error sets bit 9
// - Instruction buffer write/demap failure sets bit 9
// - Bit 8 flags hidden internal core error
// - Core error always flagged in bit 8; no config switch for it
// - Single trap without watchdog writes end method
// - End method undefined after watchdog timeout
// - Bit 3 copies privilege, forced one if unknown
// - Bit 2 cleared single, set on data cause
// - Bit 1 cleared single, set on instruction cause
// - Bit 0 cleared single, set on urgent cause
// - Handler bit chooses single or multiple trap
// - Single trap rewrites indications; multiple keeps them
`timescale 1ns/1ps
`include "uesc_params.svh"

module uesc_capture
  import uesc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  // Detectors and trap logic
  input  wire uesc_evt_t   evt_i,
  input  wire logic [63:16] err_upper_i,
  input  wire uesc_trap_t  trap_i,
  input  wire logic        handler_active_i,
  // Results to the trap logic
  output logic             fatal_error_o,
  output logic             single_trap_o,
  output logic             multiple_trap_o,
  output logic             instr_abandon_o,
  output logic      [63:0] urgent_error_status_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [63:0] stat_q;
  logic [63:0] stat_d;
  logic [63:0] pend_q;
  logic [63:0] cur;
  logic [63:0] ind_all;
  logic [31:0] cfg_q;
  logic        ack_q;
  logic        err_q;
  logic [31:0] dat_q;
  logic        fatal_q;
  logic        single_q;
  logic        multi_q;
  logic        abandon_q;
  logic        sdc_evt;
  logic        fatal_sel;
  logic        single;
  logic        multi;
  logic        req;
  logic        hit_lo;
  logic        hit_hi;
  logic        hit_cfg;

  // Region test: address bits chosen by the mask field
  function automatic logic am_hit(input logic [`UESC_PA_W-1:0] pa,
                                  input logic [31:0] cfg);
    am_hit = |(pa[`UESC_PA_W-1:32] & cfg[`UESC_B_AM_H:`UESC_B_AM_L]);
  endfunction

  // Byte-lane merge of a write into a word
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
    for (int i = 0; i < 4; i++) begin
      lane_merge[8*i +: 8] = be[i] ? wd[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  // ----------------------------------------------------------------
  // Error detection
  // ----------------------------------------------------------------
  assign fatal_sel = cfg_q[`UESC_B_FATAL_SEL];

  // Corruption sources merged into one event
  assign sdc_evt = evt_i.small_corrupt
                 | (evt_i.acc_valid & evt_i.acc_cacheable
                    & (evt_i.acc_pa >= `UESC_PA_LIMIT))
                 | (evt_i.acc_valid & am_hit(evt_i.acc_pa, cfg_q))
                 | (evt_i.ext_damage & ~fatal_sel)
                 | evt_i.dbuf_tag_err;

  // Indications seen this cycle
  always_comb begin
    cur                      = '0;
    cur[63:`UESC_B_EXT_L]    = err_upper_i;
    cur[`UESC_B_SDC]         = sdc_evt;
    cur[`UESC_B_WDT]         = evt_i.wdt_first;
    cur[`UESC_B_DTLB]        = evt_i.dtlb_load_ue;
    cur[`UESC_B_DTLB]        = cur[`UESC_B_DTLB] | evt_i.dtlb_write_fail
                               | evt_i.dtlb_demap_fail;
    cur[`UESC_B_ITLB]        = evt_i.itlb_load_ue;
    cur[`UESC_B_ITLB]        = cur[`UESC_B_ITLB] | evt_i.itlb_write_fail
                               | evt_i.itlb_demap_fail;
    cur[`UESC_B_CORE]        = evt_i.core_ue;
  end

  // Everything detected since the last single trap, this cycle included
  assign ind_all = pend_q | cur;

  // Pending indications; cleared by a single trap, so an event in the trap cycle reaches only the status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q <= `UESC_STAT_RST;
    end else if (single) begin
      pend_q <= `UESC_STAT_RST;
    end else begin
      pend_q <= ind_all;
    end
  end

  // ----------------------------------------------------------------
  // Trap classification
  // ----------------------------------------------------------------
  assign single = trap_i.req & ~handler_active_i;
  assign multi  = trap_i.req & handler_active_i;

  // Status update on a trap
  always_comb begin
    stat_d = stat_q;
    if (single) begin
      stat_d[63:`UESC_B_IND_L] = ind_all[63:`UESC_B_IND_L];
      if (ind_all[`UESC_B_WDT]) begin
        stat_d[`UESC_B_END_H:`UESC_B_END_L] = `UESC_END_UNDEF;
      end else begin
        stat_d[`UESC_B_END_H:`UESC_B_END_L] = trap_i.end_method;
      end
      stat_d[`UESC_B_SUPERVISOR_MODE_COPY]  = trap_i.supervisor_mode_copy | trap_i.pstate_ue;
      stat_d[`UESC_B_MDAE]  = 1'b0;
      stat_d[`UESC_B_MIAE]  = 1'b0;
      stat_d[`UESC_B_MIUGE] = 1'b0;
    end else if (multi) begin
      if (trap_i.cause_dae) begin
        stat_d[`UESC_B_MDAE] = 1'b1;
      end
      if (trap_i.cause_iae) begin
        stat_d[`UESC_B_MIAE] = 1'b1;
      end
      if (trap_i.cause_iuge) begin
        stat_d[`UESC_B_MIUGE] = 1'b1;
      end
    end
    stat_d = stat_d & `UESC_STAT_MASK;
  end

  // Status register, written by hardware only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= `UESC_STAT_RST;
    end else begin
      stat_q <= stat_d;
    end
  end

  // Trap result pulses
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      single_q  <= 1'b0;
      multi_q   <= 1'b0;
      abandon_q <= 1'b0;
      fatal_q   <= 1'b0;
    end else begin
      single_q  <= single;
      multi_q   <= multi;
      abandon_q <= single & ind_all[`UESC_B_WDT];
      fatal_q   <= evt_i.ext_damage & fatal_sel;
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  assign req     = cyc_i & stb_i & ~ack_q & ~err_q;
  assign hit_lo  = adr_i == `UESC_OFS_STAT_LO;
  assign hit_hi  = adr_i == `UESC_OFS_STAT_HI;
  assign hit_cfg = adr_i == `UESC_OFS_CFG;

  // Answer one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      ack_q <= req & (hit_lo | hit_hi | hit_cfg);
      err_q <= req & ~(hit_lo | hit_hi | hit_cfg);
    end
  end

  // Read data; status words ignore writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (req & ~we_i) begin
      unique case (1'b1)
        hit_lo:  dat_q <= stat_q[31:0];
        hit_hi:  dat_q <= stat_q[63:32];
        hit_cfg: dat_q <= cfg_q;
        default: dat_q <= 32'h0000_0000;
      endcase
    end
  end

  // Config register: fatal select and address mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= `UESC_CFG_RST;
    end else if (req & we_i & hit_cfg) begin
      cfg_q <= lane_merge(cfg_q, dat_i, sel_i) & `UESC_CFG_MASK;
    end
  end

  assign dat_o                 = dat_q;
  assign ack_o                 = ack_q;
  assign err_o                 = err_q;
  assign fatal_error_o         = fatal_q;
  assign single_trap_o         = single_q;
  assign multiple_trap_o       = multi_q;
  assign instr_abandon_o       = abandon_q;
  assign urgent_error_status_o = stat_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence single_s;
    trap_i.req && !handler_active_i;
  endsequence

  sequence multi_s;
    trap_i.req && handler_active_i;
  endsequence

  sdc_small_a: assert property (@(posedge clk_i) disable iff (rst_i)
    evt_i.small_corrupt && !trap_i.req ##1 !trap_i.req ##1 single_s
    |=> stat_q[`UESC_B_SDC])
    else $error("small corruption lost before trap");

  pa_limit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (single_s and (evt_i.acc_valid && evt_i.acc_cacheable
     && evt_i.acc_pa >= `UESC_PA_LIMIT)) |=> stat_q[`UESC_B_SDC])
    else $error("high cacheable address not flagged");

  fatal_path_a: assert property (@(posedge clk_i) disable iff (rst_i)
    evt_i.ext_damage |=> (fatal_error_o == $past(fatal_sel)))
    else $error("fatal select not honoured");

  wdt_abandon_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (single_s and evt_i.wdt_first) |=> instr_abandon_o && stat_q[`UESC_B_WDT])
    else $error("watchdog trap not abandoned");

  end_method_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (single_s and !ind_all[`UESC_B_WDT])
    |=> stat_q[`UESC_B_END_H:`UESC_B_END_L] == $past(trap_i.end_method))
    else $error("end method not captured");

  supervisor_mode_copy_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (single_s and trap_i.pstate_ue) |=> stat_q[`UESC_B_SUPERVISOR_MODE_COPY])
    else $error("unknown privilege not forced to one");

  nested_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    single_s |=> stat_q[2:0] == 3'h0 ##1 (multi_q || stat_q[2:0] == 3'h0))
    else $error("nested causes not cleared");

  nested_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (multi_s and trap_i.cause_iuge) |=> stat_q[`UESC_B_MIUGE]
    && $stable(stat_q[63:`UESC_B_IND_L]))
    else $error("nested urgent cause or indications wrong");

  reserved_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o && !$past(we_i) && $past(hit_lo)
    |-> (dat_o & 32'(~`UESC_STAT_MASK)) == 32'h0000_0000)
    else $error("reserved bits read nonzero");

  bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

endmodule // uesc_capture

//--- src/uesc_params.svh
// Constants for the urgent error status capture block
`ifndef UESC_PARAMS_SVH
`define UESC_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses on the bus)
// ----------------------------------------------------------------
`define UESC_OFS_STAT_LO 8'h00
`define UESC_OFS_STAT_HI 8'h04
`define UESC_OFS_CFG     8'h08

// ----------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------
`define UESC_B_SDC   15
`define UESC_B_WDT   14
`define UESC_B_DTLB  10
`define UESC_B_ITLB  9
`define UESC_B_CORE  8
`define UESC_B_END_H 5
`define UESC_B_END_L 4
`define UESC_B_SUPERVISOR_MODE_COPY  3
`define UESC_B_MDAE  2
`define UESC_B_MIAE  1
`define UESC_B_MIUGE 0
`define UESC_B_IND_L 6
`define UESC_B_EXT_L 16

// ----------------------------------------------------------------
// Config field positions
// ----------------------------------------------------------------
`define UESC_B_FATAL_SEL 0
`define UESC_B_AM_L      16
`define UESC_B_AM_H      26

// ----------------------------------------------------------------
// Masks, limits and reset values
// ----------------------------------------------------------------
`define UESC_STAT_MASK 64'hffff_ffff_ffff_c73f
`define UESC_CFG_MASK  32'h07ff_0001
`define UESC_PA_W      43
`define UESC_PA_LIMIT  43'h400_0000_0000
`define UESC_STAT_RST  64'h0000_0000_0000_0000
`define UESC_CFG_RST   32'h0000_0000
`define UESC_END_UNDEF 2'h0

`endif

//--- src/uesc_pkg.sv
// Types shared by the urgent error status capture block
`include "uesc_params.svh"
package uesc_pkg;

  // End method of the trapped instruction
  typedef enum logic [1:0] {
    UESC_END_PRECISE  = 2'h0,
    UESC_END_RETRY_NP = 2'h1,
    UESC_END_RSVD     = 2'h2,
    UESC_END_NO_RETRY = 2'h3
  } uesc_end_t;

  // Error detector reports, one-cycle pulses
  typedef struct packed {
    logic                  small_corrupt;
    logic                  acc_valid;
    logic                  acc_cacheable;
    logic [`UESC_PA_W-1:0] acc_pa;
    logic                  ext_damage;
    logic                  dbuf_tag_err;
    logic                  wdt_first;
    logic                  dtlb_load_ue;
    logic                  dtlb_write_fail;
    logic                  dtlb_demap_fail;
    logic                  itlb_load_ue;
    logic                  itlb_write_fail;
    logic                  itlb_demap_fail;
    logic                  core_ue;
  } uesc_evt_t;

  // Trap request from the trap logic
  typedef struct packed {
    logic      req;
    logic      cause_dae;
    logic      cause_iae;
    logic      cause_iuge;
    uesc_end_t end_method;
    logic      supervisor_mode_copy;
    logic      pstate_ue;
  } uesc_trap_t;

endpackage
